// [rtl/mal_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module mal_regs
    import mal_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE       = 16'h1234, // Arbitrary value
    parameter logic [11:0] DEVICE_CODE      = 12'h5a5,  // Arbitrary value
    parameter logic [3:0]  REVISION_CODE    = 4'h1,     // Arbitrary value
    parameter int          SHUNT_LONG_CYC   = SHUNT_CT_LONG_CYC,
    parameter int          SHUNT_SHORT_CYC  = SHUNT_CT_SHORT_CYC
) (
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  regPtr,
    input  wire logic        regWrEn,
    input  wire logic [15:0] regWrData,
    input  wire logic        regRdEn,
    input  wire mal_meas_t   meas,
    input  wire logic        convDone,
    input  wire logic        mathOverflow,
    output logic [15:0]      regRdData_q,
    output mal_cfg_t         cfg_q,
    output logic [15:0]      shuntConvCycles_q,
    output logic             alertOut_q,
    output logic             alertOe_q
);

    logic [15:0] config_q;
    logic [15:0] config_d;
    logic [15:0] mask_q;
    logic [15:0] mask_d;
    logic [15:0] limitValue_q;
    logic [15:0] limitValue_d;
    logic [15:0] regRdData_d;
    mal_cfg_t    cfg_d;
    logic [15:0] shuntConvCycles_d;
    logic        alertOe_d;
    logic        alertOut_d;
    logic        convClear;
    logic        limitHit;
    logic        cfgWrite;
    logic        maskWrite;
    logic        limitWrite;
    logic        maskRead;
    logic        alertActive;
    mal_sel_t    sel;

    function automatic logic [15:0] shunt_cycles(input logic [2:0] code);
        if (code == SHUNT_CT_SHORT_CODE) begin
            return 16'(SHUNT_SHORT_CYC);
        end else begin
            return 16'(SHUNT_LONG_CYC);
        end
    endfunction : shunt_cycles

    // Sticky flag: a set in the same cycle as a clear wins
    function automatic logic flag_next(input logic cur, input logic clr, input logic set);
        return set | (cur & ~clr);
    endfunction : flag_next

    // Pointer decode for strobes that change state
    always_comb begin
        cfgWrite   = 1'b0;
        maskWrite  = 1'b0;
        limitWrite = 1'b0;
        maskRead   = 1'b0;
        if (regWrEn) begin
            if (regPtr == CONFIG_PTR) begin
                cfgWrite = 1'b1;
            end else if (regPtr == MASK_PTR) begin
                maskWrite = 1'b1;
            end else if (regPtr == LIMIT_PTR) begin
                limitWrite = 1'b1;
            end
        end
        if (regRdEn && regPtr == MASK_PTR) begin
            maskRead = 1'b1;
        end
        // Ready flag clears on mask read or config write outside power-down
        convClear = maskRead;
        if (cfgWrite && regWrData[MODE_LSB +: 3] != MODE_POWER_DOWN) begin
            convClear = 1'b1;
        end
    end

    assign sel = '{shuntOverEnable:  mask_q[SHUNT_OVER_BIT],
                   shuntUnderEnable: mask_q[SHUNT_UNDER_BIT],
                   busOverEnable:    mask_q[BUS_OVER_BIT],
                   busUnderEnable:   mask_q[BUS_UNDER_BIT],
                   powerOverEnable:  mask_q[POWER_OVER_BIT],
                   readyAlertEnable: mask_q[READY_ALERT_BIT]};

    mal_alert_cmp u_cmp (
        .sys_clk            (sys_clk),
        .resetn             (resetn),
        .sel                (sel),
        .limitValue         (limitValue_q),
        .meas               (meas),
        .conversionDoneFlag (mask_q[CONV_DONE_BIT]),
        .limitHit_q         (limitHit)
    );

    // Register writes and flag updates
    always_comb begin
        config_d     = config_q;
        mask_d       = mask_q;
        limitValue_d = limitValue_q;
        if (cfgWrite && regWrData[CFG_RESET_BIT]) begin
            config_d     = CONFIG_RESET;
            mask_d       = MASK_RESET;
            limitValue_d = LIMIT_RESET;
        end else begin
            if (cfgWrite) begin
                config_d = regWrData & ~(16'h1 << CFG_RESET_BIT);
            end
            if (limitWrite) begin
                limitValue_d = regWrData;
            end
            if (maskWrite) begin
                mask_d = (regWrData & MASK_WRITABLE) | (mask_q & ~MASK_WRITABLE);
            end
            mask_d[CONV_DONE_BIT] = flag_next(mask_q[CONV_DONE_BIT], convClear, convDone);
            if (mask_q[LATCH_BIT]) begin
                mask_d[ALERT_FLAG_BIT] = flag_next(mask_q[ALERT_FLAG_BIT], maskRead, limitHit);
            end else begin
                mask_d[ALERT_FLAG_BIT] = limitHit;
            end
            mask_d[OVERFLOW_BIT] = mathOverflow;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            config_q     <= CONFIG_RESET;
            mask_q       <= MASK_RESET;
            limitValue_q <= LIMIT_RESET;
        end else begin
            config_q     <= config_d;
            mask_q       <= mask_d;
            limitValue_q <= limitValue_d;
        end
    end

    // Read path
    always_comb begin
        regRdData_d = regRdData_q;
        if (regRdEn) begin
            if (regPtr == CONFIG_PTR) begin
                regRdData_d = config_q;
            end else if (regPtr == MASK_PTR) begin
                regRdData_d = mask_q;
            end else if (regPtr == LIMIT_PTR) begin
                regRdData_d = limitValue_q;
            end else if (regPtr == MAKER_PTR) begin
                regRdData_d = MAKER_CODE;
            end else if (regPtr == DIE_PTR) begin
                regRdData_d = {DEVICE_CODE, REVISION_CODE};
            end else begin
                regRdData_d = 16'h0000;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            regRdData_q <= 16'h0000;
        end else begin
            regRdData_q <= regRdData_d;
        end
    end

    // Conversion setup outputs
    always_comb begin
        cfg_d = '{averagingCount: config_q[AVG_LSB +: 3],
                  busConvTime:    config_q[BUS_CT_LSB +: 3],
                  shuntConvTime:  config_q[SHUNT_CT_LSB +: 3],
                  opMode:         config_q[MODE_LSB +: 3]};
        shuntConvCycles_d = shunt_cycles(config_q[SHUNT_CT_LSB +: 3]);
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            cfg_q             <= '0;
            shuntConvCycles_q <= 16'h0000;
        end else begin
            cfg_q             <= cfg_d;
            shuntConvCycles_q <= shuntConvCycles_d;
        end
    end

    // Alert pin, open drain: data low, enable pulls it down
    always_comb begin
        alertActive = mask_q[ALERT_FLAG_BIT];
        alertOut_d  = 1'b0;
        // Drive low when the pin level must be low
        alertOe_d   = mask_q[POLARITY_BIT] ? !alertActive : alertActive;
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            alertOut_q <= 1'b0;
            alertOe_q  <= 1'b0;
        end else begin
            alertOut_q <= alertOut_d;
            alertOe_q  <= alertOe_d;
        end
    end

endmodule : mal_regs
`default_nettype wire

// [rtl/mal_pkg.sv]
package mal_pkg;

    // Register pointers
    localparam logic [7:0] CONFIG_PTR = 8'h00;
    localparam logic [7:0] MASK_PTR   = 8'h06;
    localparam logic [7:0] LIMIT_PTR  = 8'h07;
    localparam logic [7:0] MAKER_PTR  = 8'hfe;
    localparam logic [7:0] DIE_PTR    = 8'hff;

    // Reset values
    localparam logic [15:0] CONFIG_RESET = 16'h4000;
    localparam logic [15:0] MASK_RESET   = 16'h0000;
    localparam logic [15:0] LIMIT_RESET  = 16'h0000;

    // Configuration fields
    localparam int CFG_RESET_BIT = 15;
    localparam int AVG_LSB       = 9;
    localparam int BUS_CT_LSB    = 6;
    localparam int SHUNT_CT_LSB  = 3;
    localparam int MODE_LSB      = 0;
    localparam logic [2:0] MODE_POWER_DOWN = 3'h0;

    // Mask/enable fields
    localparam int SHUNT_OVER_BIT   = 15;
    localparam int SHUNT_UNDER_BIT  = 14;
    localparam int BUS_OVER_BIT     = 13;
    localparam int BUS_UNDER_BIT    = 12;
    localparam int POWER_OVER_BIT   = 11;
    localparam int READY_ALERT_BIT  = 10;
    localparam int ALERT_FLAG_BIT   = 4;
    localparam int CONV_DONE_BIT    = 3;
    localparam int OVERFLOW_BIT     = 2;
    localparam int POLARITY_BIT     = 1;
    localparam int LATCH_BIT        = 0;
    localparam logic [15:0] MASK_WRITABLE = 16'hffe3;

    // Die identifier fields
    localparam int DEVICE_CODE_LSB = 4;
    localparam int REVISION_LSB    = 0;

    // Shunt conversion times
    localparam int CLK_PERIOD_NS      = 50;
    localparam int SHUNT_CT_LONG_NS   = 1036000;
    localparam int SHUNT_CT_SHORT_NS  = 150000;
    localparam int SHUNT_CT_LONG_CYC  = SHUNT_CT_LONG_NS / CLK_PERIOD_NS;
    localparam int SHUNT_CT_SHORT_CYC = SHUNT_CT_SHORT_NS / CLK_PERIOD_NS;
    localparam logic [2:0] SHUNT_CT_LONG_CODE  = 3'h4;
    localparam logic [2:0] SHUNT_CT_SHORT_CODE = 3'h0;

    typedef struct packed {
        logic [2:0] averagingCount;
        logic [2:0] busConvTime;
        logic [2:0] shuntConvTime;
        logic [2:0] opMode;
    } mal_cfg_t;

    typedef struct packed {
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] power;
    } mal_meas_t;

    typedef struct packed {
        logic        shuntOverEnable;
        logic        shuntUnderEnable;
        logic        busOverEnable;
        logic        busUnderEnable;
        logic        powerOverEnable;
        logic        readyAlertEnable;
    } mal_sel_t;

endpackage : mal_pkg

// [rtl/mal_alert_cmp.sv]
`timescale 1ns/1ps
`default_nettype none
module mal_alert_cmp
    import mal_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    input  wire mal_sel_t    sel,
    input  wire logic [15:0] limitValue,
    input  wire mal_meas_t   meas,
    input  wire logic        conversionDoneFlag,
    output logic             limitHit_q
);

    logic limitHit_d;

    always_comb begin
        limitHit_d = 1'b0;
        if (sel.shuntOverEnable) begin
            limitHit_d = $signed(meas.shunt) > $signed(limitValue);
        end else if (sel.shuntUnderEnable) begin
            limitHit_d = $signed(meas.shunt) < $signed(limitValue);
        end else if (sel.busOverEnable) begin
            limitHit_d = meas.bus > limitValue;
        end else if (sel.busUnderEnable) begin
            limitHit_d = meas.bus < limitValue;
        end else if (sel.powerOverEnable) begin
            limitHit_d = meas.power > limitValue;
        end else if (sel.readyAlertEnable) begin
            limitHit_d = conversionDoneFlag;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            limitHit_q <= 1'b0;
        end else begin
            limitHit_q <= limitHit_d;
        end
    end

endmodule : mal_alert_cmp
`default_nettype wire

// [dv/mal_regs_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module mal_regs_chk
    import mal_pkg::*;
#(
    parameter logic [15:0] MAKER_CODE      = 16'h0000,
    parameter logic [11:0] DEVICE_CODE     = 12'h000,
    parameter logic [3:0]  REVISION_CODE   = 4'h0,
    parameter int          SHUNT_LONG_CYC  = 1,
    parameter int          SHUNT_SHORT_CYC = 1
) (
    input wire logic        sys_clk,
    input wire logic        resetn,
    input wire logic [7:0]  regPtr,
    input wire logic        regWrEn,
    input wire logic [15:0] regWrData,
    input wire logic        regRdEn,
    input wire logic [15:0] regRdData_q,
    input wire mal_cfg_t    cfg_q,
    input wire logic [15:0] shuntConvCycles_q,
    input wire logic        alertOut_q,
    input wire logic        alertOe_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    wire mapped = regPtr inside {CONFIG_PTR, MASK_PTR, LIMIT_PTR, MAKER_PTR, DIE_PTR};
    rd_hold_a: assert property (!regRdEn |=> $stable(regRdData_q)) else $error("read word moved");
    maker_rd_a: assert property (regRdEn && regPtr == MAKER_PTR |=> regRdData_q == MAKER_CODE)
        else $error("maker code wrong");
    die_rd_a: assert property (regRdEn && regPtr == DIE_PTR |=> regRdData_q == {DEVICE_CODE, REVISION_CODE})
        else $error("die code wrong");
    unmapped_rd_a: assert property (regRdEn && !mapped |=> regRdData_q == 16'h0000)
        else $error("unmapped read not zero");
    limit_back_a: assert property (regWrEn && regPtr == LIMIT_PTR ##2 regRdEn && regPtr == LIMIT_PTR
        |=> regRdData_q == $past(regWrData, 3)) else $error("limit readback wrong");
    cfg_track_a: assert property (regWrEn && regPtr == CONFIG_PTR && !regWrData[15] ##1 !regWrEn [*2]
        |=> cfg_q == $past(regWrData[11:0], 3)) else $error("config fields wrong");
    short_ct_a: assert property ((cfg_q.shuntConvTime == 3'h0) [*3] |-> shuntConvCycles_q == SHUNT_SHORT_CYC)
        else $error("short time wrong");
    long_ct_a: assert property ((cfg_q.shuntConvTime != 3'h0) [*3] |-> shuntConvCycles_q == SHUNT_LONG_CYC)
        else $error("long time wrong");
    open_drain_a: assert property (alertOut_q == 1'b0) else $error("alert data not low");
    cover property (regRdEn && regPtr == MAKER_PTR);
    cover property ($rose(alertOe_q));
    cover property ($fell(alertOe_q));
endmodule : mal_regs_chk
bind mal_regs mal_regs_chk #(.MAKER_CODE(MAKER_CODE), .DEVICE_CODE(DEVICE_CODE), .REVISION_CODE(REVISION_CODE),
    .SHUNT_LONG_CYC(SHUNT_LONG_CYC), .SHUNT_SHORT_CYC(SHUNT_SHORT_CYC)) chk (.sys_clk(sys_clk), .resetn(resetn),
    .regPtr(regPtr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn), .regRdData_q(regRdData_q),
    .cfg_q(cfg_q), .shuntConvCycles_q(shuntConvCycles_q), .alertOut_q(alertOut_q), .alertOe_q(alertOe_q));
`default_nettype wire

// [dv/mal_host.sv]
`timescale 1ns/1ps
`default_nettype none
module mal_host (
    input  wire logic   sys_clk,
    output logic [7:0]  regPtr = 8'h00,
    output logic        regWrEn = 1'b0,
    output logic [15:0] regWrData = 16'h0000,
    output logic        regRdEn = 1'b0
);
    task automatic xfer(input logic wr, input logic [7:0] p, input logic [15:0] d);
        @(posedge sys_clk);
        regPtr    <= p;
        regWrData <= d;
        regWrEn   <= wr;
        regRdEn   <= !wr;
        @(posedge sys_clk);
        regWrEn   <= 1'b0;
        regRdEn   <= 1'b0;
        regPtr    <= ~p;
        regWrData <= ~d;
    endtask : xfer
endmodule : mal_host
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import mal_pkg::*;
    localparam logic [15:0] MAKER = 16'hc3a5; // Arbitrary value
    localparam logic [15:0] DIE   = 16'h7e92; // Arbitrary value
    logic        sys_clk = 1'b0;
    logic        resetn = 1'b0;
    logic [7:0]  regPtr;
    logic        regWrEn;
    logic [15:0] regWrData;
    logic        regRdEn;
    mal_meas_t   meas = '0;
    logic        convDone = 1'b0;
    logic        mathOverflow = 1'b0;
    logic [15:0] regRdData_q;
    mal_cfg_t    cfg_q;
    logic [15:0] shuntConvCycles_q;
    logic        alertOe_q;
    logic        rdSeen = 1'b0;
    logic [15:0] expRd[$];
    logic [15:0] v;
    int          fails = 0;
    int          n_checks = 0;
    int          seed = 97;
    always #25 sys_clk = ~sys_clk;
    mal_host host (.sys_clk(sys_clk), .regPtr(regPtr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn));
    mal_regs #(.MAKER_CODE(MAKER), .DEVICE_CODE(DIE[15:4]), .REVISION_CODE(DIE[3:0]), .SHUNT_LONG_CYC(40),
        .SHUNT_SHORT_CYC(12)) uut (.sys_clk(sys_clk), .resetn(resetn), .regPtr(regPtr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn), .meas(meas), .convDone(convDone), .mathOverflow(mathOverflow),
        .regRdData_q(regRdData_q), .cfg_q(cfg_q), .shuntConvCycles_q(shuntConvCycles_q), .alertOut_q(),
        .alertOe_q(alertOe_q));
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] %s exp %h got %h", nm, e, g);
        end
    endtask : chk16
    task automatic chkPin(input logic e);
        chk16("alertOe", {15'h0, e}, {15'h0, alertOe_q});
    endtask : chkPin
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        host.xfer(1'b1, p, d);
    endtask : wr
    task automatic rd(input logic [7:0] p, input logic [15:0] e);
        expRd.push_back(e);
        host.xfer(1'b0, p, 16'h0000);
    endtask : rd
    task automatic setMeas(input logic [15:0] x);
        @(posedge sys_clk);
        meas <= {x, x, x};
        repeat (5) @(posedge sys_clk);
    endtask : setMeas
    task automatic pulse;
        @(posedge sys_clk);
        convDone <= 1'b1;
        @(posedge sys_clk);
        convDone <= 1'b0;
        repeat (5) @(posedge sys_clk);
    endtask : pulse
    task automatic end_sim;
        $display("n_checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_sim
    always @(posedge sys_clk) begin
        if (rdSeen) chk16("rdData", expRd.pop_front(), regRdData_q);
        rdSeen <= regRdEn;
    end
    initial begin
        repeat (4000) @(posedge sys_clk);
        fails++;
        end_sim;
    end
    initial begin
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(CONFIG_PTR, CONFIG_RESET);
        rd(MASK_PTR, MASK_RESET);
        rd(LIMIT_PTR, LIMIT_RESET);
        chk16("shuntCyc", 16'h000c, shuntConvCycles_q);
        wr(MAKER_PTR, ~MAKER);
        wr(DIE_PTR, ~DIE);
        rd(MAKER_PTR, MAKER);
        rd(DIE_PTR, DIE);
        rd(8'h10, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            v = 16'($random(seed));
            wr(LIMIT_PTR, v);
            rd(LIMIT_PTR, v);
        end
        wr(CONFIG_PTR, 16'h4025);
        rd(CONFIG_PTR, 16'h4025);
        chk16("shuntCyc", 16'h0028, shuntConvCycles_q);
        wr(CONFIG_PTR, 16'hc025);
        rd(CONFIG_PTR, CONFIG_RESET);
        rd(LIMIT_PTR, LIMIT_RESET);
        wr(LIMIT_PTR, 16'h7d00);
        for (int i = 0; i < 5; i++) begin
            wr(MASK_PTR, 16'h8000 >> i);
            setMeas(i[0] ? 16'h7cff : 16'h7d01);
            chkPin(1'b1);
            setMeas(16'h7d00);
            chkPin(1'b0);
        end
        wr(MASK_PTR, 16'hc000);
        setMeas(16'h7cff);
        chkPin(1'b0);
        wr(MASK_PTR, 16'h8002);
        setMeas(16'h7d01);
        chkPin(1'b0);
        setMeas(16'h0000);
        chkPin(1'b1);
        wr(MASK_PTR, 16'h8001);
        setMeas(16'h7d01);
        setMeas(16'h0000);
        chkPin(1'b1);
        rd(MASK_PTR, 16'h8011);
        setMeas(16'h0000);
        chkPin(1'b0);
        wr(MASK_PTR, 16'h0400);
        pulse;
        chkPin(1'b1);
        rd(MASK_PTR, 16'h0418);
        setMeas(16'h0000);
        chkPin(1'b0);
        pulse;
        wr(CONFIG_PTR, 16'h4005);
        mathOverflow <= 1'b1;
        setMeas(16'h0000);
        rd(MASK_PTR, 16'h0404);
        repeat (3) @(posedge sys_clk);
        end_sim;
    end
endmodule : testbench
`default_nettype wire
